// ---- core/sfnc_converter.sv ----
// small float, fixed-point and normalized integer conversion datapath, one register stage
`timescale 1ns/1ps
module sfnc_converter #(
  parameter int NORM_W = sfnc_pkg::SFNC_NORM_W_DEF
) (
  // clock, reset and clock enable
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  input  wire logic              enable_in,
  // request
  input  wire logic              valid_in,
  input  wire sfnc_pkg::sfnc_op_t op_in,
  input  wire logic [31:0]       data_in,
  input  wire logic              round_to_zero_in,
  // result
  output logic                   valid_out,
  output logic      [31:0]       result_out,
  output logic                   special_out
);
  import sfnc_pkg::*;

  if (NORM_W < SFNC_NORM_W_MIN || NORM_W > SFNC_NORM_W_MAX) begin : norm_w_check
    $error("NORM_W must lie between 2 and 24");
  end

  localparam logic [63:0]       UMAX  = (64'h1 << NORM_W) - 64'h1;
  localparam logic [63:0]       SMAX  = (64'h1 << (NORM_W - 1)) - 64'h1;
  localparam logic [NORM_W-1:0] SMIN  = {1'b1, {(NORM_W-1){1'b0}}};
  localparam logic [63:0]       HALF  = 64'h0000_0000_8000_0000;
  localparam logic [32:0]       FONE  = 33'h1_0000_0000;

  // |f| clamped to one, as a fraction scaled by 2^32; NaN reads as zero
  function automatic logic [32:0] f32_frac(input logic [31:0] f);
    logic [7:0]  e;
    logic [32:0] sig;
    logic [32:0] r;
    e   = f[30:23];
    sig = {9'h000, (e != 8'h00), f[22:0]};
    if (e == 8'hff && f[22:0] != 23'h0) begin
      r = 33'h0;
    end else if (e >= 8'h7f) begin
      r = FONE;
    end else if (e >= 8'h76) begin
      r = sig << (e - 8'h76);
    end else begin
      r = sig >> (8'h76 - e);
    end
    return r;
  endfunction

  // repeating a w-bit code c forever behind the point gives exactly c / (2^w - 1)
  function automatic logic [31:0] rep_frac(input logic [23:0] v, input int w);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 32; i++) begin
      r[31-i] = v[w - 1 - (i % w)];
    end
    return r;
  endfunction

  // small float units
  logic [31:0] half_val;
  logic [31:0] uf11_val;
  logic [31:0] uf10_val;
  logic        half_spec;
  logic        uf11_spec;
  logic        uf10_spec;
  logic [10:0] uf11_code;
  logic [9:0]  uf10_code;

  sfnc_small_dec #(.MW(SFNC_HALF_MW), .HAS_SIGN(1)) half_dec (
    .code_in     (data_in[15:0]),
    .value_out   (half_val),
    .special_out (half_spec)
  );

  sfnc_small_dec #(.MW(SFNC_UF11_MW), .HAS_SIGN(0)) uf11_dec (
    .code_in     (data_in[10:0]),
    .value_out   (uf11_val),
    .special_out (uf11_spec)
  );

  sfnc_small_dec #(.MW(SFNC_UF10_MW), .HAS_SIGN(0)) uf10_dec (
    .code_in     (data_in[9:0]),
    .value_out   (uf10_val),
    .special_out (uf10_spec)
  );

  sfnc_small_enc #(.MW(SFNC_UF11_MW)) uf11_enc (
    .f32_in   (data_in),
    .rtz_in   (round_to_zero_in),
    .code_out (uf11_code)
  );

  sfnc_small_enc #(.MW(SFNC_UF10_MW)) uf10_enc (
    .f32_in   (data_in),
    .rtz_in   (round_to_zero_in),
    .code_out (uf10_code)
  );

  // result stage
  logic              valid_r;
  logic              valid_nxt;
  logic [31:0]       result_r;
  logic [31:0]       result_nxt;
  logic              special_r;
  logic              special_nxt;
  logic              f32_special;
  logic [31:0]       fix_mag;
  logic [NORM_W-1:0] ucode;
  logic [NORM_W-1:0] scode;
  logic [NORM_W-1:0] smag;
  logic [32:0]       ffrac;
  logic [63:0]       uprod;
  logic [63:0]       sprod;
  logic [NORM_W-1:0] uq;
  logic [NORM_W-1:0] sq;
  logic [NORM_W-1:0] sres;

  always_comb begin
    f32_special = (data_in[30:23] == 8'hff);
    fix_mag     = data_in[31] ? (32'h0 - data_in) : data_in;
    ucode       = data_in[NORM_W-1:0];
    scode       = data_in[NORM_W-1:0];
    smag        = scode[NORM_W-1] ? (~scode + NORM_W'(1)) : scode;
    ffrac       = f32_frac(data_in);
    // multiply instead of divide: the scale is a constant, so no divisor can be zero
    uprod       = 64'(ffrac) * UMAX + HALF;
    sprod       = 64'(ffrac) * SMAX + HALF;
    uq          = uprod[32 +: NORM_W];
    sq          = sprod[32 +: NORM_W];
    sres        = data_in[31] ? (NORM_W'(0) - sq) : sq;
    valid_nxt   = valid_in;
    special_nxt = 1'b0;
    result_nxt  = result_r;
    if (valid_in) begin
      case (op_in)
        SFNC_OP_HALF_TO_F32: begin
          result_nxt  = half_val;
          special_nxt = half_spec;
        end
        SFNC_OP_UF11_TO_F32: begin
          result_nxt  = uf11_val;
          special_nxt = uf11_spec;
        end
        SFNC_OP_UF10_TO_F32: begin
          result_nxt  = uf10_val;
          special_nxt = uf10_spec;
        end
        SFNC_OP_F32_TO_UF11: begin
          result_nxt  = {21'h00_0000, uf11_code};
          special_nxt = f32_special;
        end
        SFNC_OP_F32_TO_UF10: begin
          result_nxt  = {22'h00_0000, uf10_code};
          special_nxt = f32_special;
        end
        SFNC_OP_FIX_TO_F32: begin
          result_nxt = sfnc_norm_f32(data_in[31], fix_mag, 8'(SFNC_FIX_FRAC));
        end
        SFNC_OP_UNORM_TO_F32: begin
          if (ucode == {NORM_W{1'b1}}) begin
            result_nxt = SFNC_F32_ONE;
          end else begin
            result_nxt = sfnc_norm_f32(1'b0, rep_frac(24'(ucode), NORM_W), 8'(SFNC_FRAC_BITS));
          end
        end
        SFNC_OP_SNORM_TO_F32: begin
          // the most negative code lies outside the symmetric range and clamps
          if (scode == SMIN) begin
            result_nxt = SFNC_F32_NEG1;
          end else if (smag[NORM_W-2:0] == {(NORM_W-1){1'b1}}) begin
            result_nxt = scode[NORM_W-1] ? SFNC_F32_NEG1 : SFNC_F32_ONE;
          end else begin
            result_nxt = sfnc_norm_f32(scode[NORM_W-1], rep_frac(24'(smag[NORM_W-2:0]), NORM_W - 1),
                                       8'(SFNC_FRAC_BITS));
          end
        end
        SFNC_OP_F32_TO_UNORM: begin
          // negatives and NaN clamp to zero
          result_nxt  = data_in[31] ? 32'h0 : {{(32-NORM_W){1'b0}}, uq};
          special_nxt = f32_special;
        end
        SFNC_OP_F32_TO_SNORM: begin
          result_nxt  = {{(32-NORM_W){sres[NORM_W-1]}}, sres};
          special_nxt = f32_special;
        end
        default: begin
          result_nxt = SFNC_RESULT_RST;
        end
      endcase
    end
  end

  // reset takes effect even while the clock enable is low
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      valid_r   <= 1'b0;
      result_r  <= SFNC_RESULT_RST;
      special_r <= 1'b0;
    end else if (enable_in) begin
      valid_r   <= valid_nxt;
      result_r  <= result_nxt;
      special_r <= special_nxt;
    end
  end

  assign valid_out   = valid_r;
  assign result_out  = result_r;
  assign special_out = special_r;

  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  logic take;
  assign take = enable_in && valid_in;

  valid_follow_a: assert property (enable_in |=> valid_out == $past(valid_in))
    else $error("valid did not follow the request");
  freeze_hold_a: assert property (!enable_in ##1 !enable_in |-> $stable(result_out) && $stable(valid_out))
    else $error("state moved while the clock enable was low");
  half_inf_a: assert property (take && op_in == SFNC_OP_HALF_TO_F32 && data_in[14:0] == 15'h7c00
                               |=> result_out == {$past(data_in[15]), 8'hff, 23'h0})
    else $error("half infinity decoded wrong");
  half_negzero_a: assert property (take && op_in == SFNC_OP_HALF_TO_F32 && data_in[15:0] == 16'h8000
                                   |=> result_out == 32'h8000_0000)
    else $error("half negative zero decoded wrong");
  half_subnorm_a: assert property (take && op_in == SFNC_OP_HALF_TO_F32 && data_in[15:0] == 16'h0001
                                   |=> result_out == 32'h3380_0000)
    else $error("smallest half subnormal decoded wrong");
  uf11_negative_a: assert property (take && op_in == SFNC_OP_F32_TO_UF11 && data_in[31]
                                    && !(data_in[30:23] == 8'hff && data_in[22:0] != 23'h0)
                                    |=> result_out == 32'h0)
    else $error("negative value did not encode to zero");
  uf10_nan_a: assert property (take && op_in == SFNC_OP_F32_TO_UF10 && data_in[30:23] == 8'hff
                               && data_in[22:0] != 23'h0
                               |=> result_out[31:10] == 22'h0 && result_out[9:5] == 5'h1f
                                   && result_out[4:0] != 5'h00)
    else $error("NaN did not encode to a positive NaN");
  uf11_sat_a: assert property (take && op_in == SFNC_OP_F32_TO_UF11 && !data_in[31]
                               && data_in[30:23] >= 8'h8f && data_in[30:23] != 8'hff
                               |=> result_out == 32'h0000_07bf)
    else $error("large value did not saturate to the largest finite code");
  unorm_max_a: assert property (take && op_in == SFNC_OP_UNORM_TO_F32 && data_in[NORM_W-1:0] == {NORM_W{1'b1}}
                                |=> result_out == SFNC_F32_ONE)
    else $error("all-ones unsigned code did not give one");
  snorm_min_a: assert property (take && op_in == SFNC_OP_SNORM_TO_F32 && data_in[NORM_W-1:0] == SMIN
                                |=> result_out == SFNC_F32_NEG1)
    else $error("most negative signed code did not clamp to minus one");
  unorm_one_a: assert property (take && op_in == SFNC_OP_F32_TO_UNORM && data_in == SFNC_F32_ONE
                                |=> result_out[NORM_W-1:0] == {NORM_W{1'b1}})
    else $error("one did not encode to the all-ones code");
  snorm_neg1_a: assert property (take && op_in == SFNC_OP_F32_TO_SNORM && data_in == SFNC_F32_NEG1
                                 |=> result_out[NORM_W-1:0] == NORM_W'(64'h0 - SMAX))
    else $error("minus one did not encode to the symmetric minimum");
  fix_one_a: assert property (take && op_in == SFNC_OP_FIX_TO_F32 && data_in == 32'h0001_0000
                              |=> result_out == SFNC_F32_ONE)
    else $error("fixed-point one converted wrong");

  // reset is checked with the default disable lifted
  reset_clear_a: assert property (disable iff (1'b0) !reset_n_in
                                  |=> !valid_out && !special_out && result_out == SFNC_RESULT_RST)
    else $error("reset left an output set");
  idle_hold_a: assert property (enable_in && !valid_in
                                |=> !valid_out && !special_out && $stable(result_out))
    else $error("idle edge moved the outputs");

  // decode corners
  half_special_a: assert property (take && op_in == SFNC_OP_HALF_TO_F32 && data_in[14:10] == 5'h1f
                                   |=> special_out)
    else $error("half special value not flagged");
  uf11_sub_a: assert property (take && op_in == SFNC_OP_UF11_TO_F32 && data_in[10:0] == 11'h001
                               |=> result_out == 32'h3580_0000)
    else $error("11-bit subnormal decoded wrong");
  uf10_sub_a: assert property (take && op_in == SFNC_OP_UF10_TO_F32 && data_in[9:0] == 10'h001
                               |=> result_out == 32'h3600_0000)
    else $error("10-bit subnormal decoded wrong");

  // encode corners
  uf11_nan_a: assert property (take && op_in == SFNC_OP_F32_TO_UF11 && data_in == 32'hffc0_0000
                               |=> result_out == 32'h0000_07e0)
    else $error("NaN did not encode to the positive NaN");

  // normalized and fixed-point corners
  snorm_one_a: assert property (take && op_in == SFNC_OP_F32_TO_SNORM && data_in == SFNC_F32_ONE
                                |=> result_out[NORM_W-1:0] == NORM_W'(SMAX))
    else $error("one did not encode to the largest signed code");
  fix_neg_a: assert property (take && op_in == SFNC_OP_FIX_TO_F32 && data_in == 32'h8000_0000
                              |=> result_out == 32'hc700_0000)
    else $error("most negative fixed-point value converted wrong");

  rtz_encode_c: cover property (take && op_in == SFNC_OP_F32_TO_UF11 && round_to_zero_in);
  snorm_decode_c: cover property (take && op_in == SFNC_OP_SNORM_TO_F32 ##1 take && op_in == SFNC_OP_F32_TO_SNORM);
  half_nan_c: cover property (take && op_in == SFNC_OP_HALF_TO_F32 && data_in[14:10] == 5'h1f
                              && data_in[9:0] != 10'h000);
  // a freeze just after a take, and a mid-run reset
  freeze_c: cover property (take ##1 !enable_in ##1 !enable_in);
  reset_mid_c: cover property (disable iff (1'b0) reset_n_in ##1 !reset_n_in);
endmodule

// ---- core/sfnc_pkg.sv ----
// shared constants, op codes and helpers for the small float and normalized converter
//
// Overview of operation
// - Half word holds sign, five exponent bits and ten fraction bits, high to low.
// - Half decode gives signed zero, subnormal, bias-15 normal, signed infinity or NaN.
// - Half word as integer: sign bit 15, exponent bits 14..10, fraction bits 9..0.
// - Subnormal and negative zero halves decode predictably; Inf and NaN never stall.
// - Unsigned 11-bit float: exponent bits 10..6, fraction bits 5..0, no sign.
// - Unsigned 11-bit decode: zero, subnormal, bias-15 normal, infinity, NaN.
// - Encode to 11-bit rounds nearest or toward zero; negatives zero, saturate 65024.
// - Small-float encode: minus infinity zero, plus infinity infinity, any NaN positive NaN.
// - Unsigned 10-bit float: exponent bits 9..5, fraction bits 4..0, no sign.
// - Unsigned 10-bit decode: zero, subnormal, bias-15 normal, infinity, NaN.
// - Encode to 10-bit rounds nearest or toward zero; negatives zero, saturate 64512.
// - Subnormal 11-bit and 10-bit codes decode to well-defined values.
// - Fixed-point input is 32-bit two's complement with sixteen fraction bits.
// - No division by zero or other input may stall or hang the datapath.
// - Unsigned normalized c converts to c over two-to-b minus one.
// - Signed normalized c converts to max of c over 2^(b-1)-1 and -1.
// - Float to unsigned normalized: clamp 0..1, scale by 2^b-1, round nearest.
// - Float to signed normalized: clamp -1..1, scale by 2^(b-1)-1, round nearest.
// - Normalized width is at least two, covering narrow alpha components.
package sfnc_pkg;
  localparam int          SFNC_EXP_W      = 5;
  localparam int          SFNC_HALF_MW    = 10;
  localparam int          SFNC_UF11_MW    = 6;
  localparam int          SFNC_UF10_MW    = 5;
  localparam int          SFNC_SMALL_BIAS = 15;
  localparam int          SFNC_F32_BIAS   = 127;
  localparam int          SFNC_FIX_FRAC   = 16;
  localparam int          SFNC_FRAC_BITS  = 32;
  localparam int          SFNC_NORM_W_DEF = 8;
  localparam int          SFNC_NORM_W_MIN = 2;
  localparam int          SFNC_NORM_W_MAX = 24;
  localparam logic [31:0] SFNC_F32_ONE    = 32'h3f80_0000;
  localparam logic [31:0] SFNC_F32_NEG1   = 32'hbf80_0000;
  localparam logic [31:0] SFNC_RESULT_RST = 32'h0000_0000;

  typedef enum logic [3:0] {
    SFNC_OP_HALF_TO_F32,
    SFNC_OP_UF11_TO_F32,
    SFNC_OP_UF10_TO_F32,
    SFNC_OP_F32_TO_UF11,
    SFNC_OP_F32_TO_UF10,
    SFNC_OP_FIX_TO_F32,
    SFNC_OP_UNORM_TO_F32,
    SFNC_OP_SNORM_TO_F32,
    SFNC_OP_F32_TO_UNORM,
    SFNC_OP_F32_TO_SNORM
  } sfnc_op_t;

  // index of the highest set bit, zero for an all-zero word
  function automatic logic [5:0] sfnc_msb32(input logic [31:0] v);
    logic [5:0] p;
    p = 6'h00;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        p = 6'(i);
      end
    end
    return p;
  endfunction

  // single float of mag * 2^-fb, truncating; mantissa bits below the top 24 are dropped
  function automatic logic [31:0] sfnc_norm_f32(input logic s, input logic [31:0] mag, input logic [7:0] fb);
    logic [5:0]  p;
    logic [31:0] t;
    logic [7:0]  e;
    p = sfnc_msb32(mag);
    t = mag << (6'h1f - p);
    e = 8'(SFNC_F32_BIAS) + {2'h0, p} - fb;
    return (mag == 32'h0) ? 32'h0 : {s, e, t[30:8]};
  endfunction
endpackage

// ---- core/sfnc_small_dec.sv ----
// decoder from a small float word (half, unsigned 11-bit or 10-bit) to single precision
`timescale 1ns/1ps
module sfnc_small_dec #(
  parameter int MW       = 10,
  parameter int HAS_SIGN = 1
) (
  // small float word
  input  wire logic [HAS_SIGN+sfnc_pkg::SFNC_EXP_W+MW-1:0] code_in,
  // decoded value
  output logic      [31:0]                                 value_out,
  output logic                                             special_out
);
  import sfnc_pkg::*;

  localparam int W = HAS_SIGN + SFNC_EXP_W + MW;

  logic          sgn;
  logic [4:0]    expo;
  logic [MW-1:0] man;

  always_comb begin
    sgn         = (HAS_SIGN != 0) ? code_in[W-1] : 1'b0;
    expo        = code_in[MW +: SFNC_EXP_W];
    man         = code_in[MW-1:0];
    special_out = (expo == 5'h1f);
    if (expo == 5'h00) begin
      // zero and subnormal share one path: man * 2^-(14+MW), sign kept for zero
      value_out     = sfnc_norm_f32(sgn, 32'(man), 8'(SFNC_SMALL_BIAS - 1 + MW));
      value_out[31] = sgn;
    end else if (expo == 5'h1f) begin
      // fraction carried over, so a NaN stays non-zero and an infinity stays zero
      value_out = {sgn, 8'hff, man, {(23-MW){1'b0}}};
    end else begin
      value_out = {sgn, 8'({3'h0, expo}) + 8'(SFNC_F32_BIAS - SFNC_SMALL_BIAS),
                   man, {(23-MW){1'b0}}};
    end
  end
endmodule

// ---- core/sfnc_small_enc.sv ----
// encoder from single precision to an unsigned small float (11-bit or 10-bit)
`timescale 1ns/1ps
module sfnc_small_enc #(
  parameter int MW = 6
) (
  // single precision value and rounding mode
  input  wire logic [31:0]                      f32_in,
  input  wire logic                             rtz_in,
  // encoded word
  output logic      [sfnc_pkg::SFNC_EXP_W+MW-1:0] code_out
);
  import sfnc_pkg::*;

  localparam int         W       = SFNC_EXP_W + MW;
  localparam logic [W-1:0] MAX_FIN = {5'h1e, {MW{1'b1}}};
  localparam logic [W-1:0] INF_C   = {5'h1f, {MW{1'b0}}};
  localparam logic [W-1:0] QNAN_C  = {5'h1f, 1'b1, {(MW-1){1'b0}}};

  logic [7:0]  fe;
  logic [22:0] ff;
  logic [8:0]  te;
  logic [8:0]  sv;
  logic [5:0]  sh;
  logic [47:0] ext;
  logic [4:0]  ebits;
  logic        rnd;
  logic        stk;
  logic        inc;
  logic [W:0]  code;

  always_comb begin
    fe    = f32_in[30:23];
    ff    = f32_in[22:0];
    te    = {1'b0, fe} - 9'(SFNC_F32_BIAS - SFNC_SMALL_BIAS);
    sv    = 9'h001 - te;
    // target subnormals shift the significand right; past 26 nothing survives anyway
    if (te[8] || te == 9'h000) begin
      sh    = (sv > 9'h01a) ? 6'h1a : sv[5:0];
      ebits = 5'h00;
    end else begin
      sh    = 6'h00;
      ebits = te[4:0];
    end
    ext   = {1'b1, ff, 24'h00_0000} >> sh;
    rnd   = ext[46-MW];
    stk   = |ext[45-MW:0];
    inc   = !rtz_in && rnd && (stk || ext[47-MW]);
    code  = {1'b0, ebits, ext[46 -: MW]} + (W+1)'(inc);
    if (fe == 8'hff && ff != 23'h0) begin
      code_out = QNAN_C;
    end else if (f32_in[31]) begin
      code_out = '0;
    end else if (fe == 8'hff) begin
      code_out = INF_C;
    end else if (!te[8] && te > 9'h01e) begin
      code_out = MAX_FIN;
    end else if (code >= (W+1)'(INF_C)) begin
      // rounding up from the largest finite code must not reach infinity
      code_out = MAX_FIN;
    end else begin
      code_out = code[W-1:0];
    end
  end
endmodule

// ---- sim/sfnc_feed_model.sv ----
// upstream request source model driving the converter's request port
`timescale 1ns/1ps
module sfnc_feed_model (
  // clock and reset
  input  wire logic          clk_in,
  input  wire logic          reset_n_in,
  // request toward the converter
  output logic               enable_out,
  output logic               valid_out,
  output sfnc_pkg::sfnc_op_t op_out,
  output logic [31:0]        data_out,
  output logic               rtz_out
);
  import sfnc_pkg::*;
  initial begin
    enable_out = 1'b1;
    valid_out = 1'b0;
    op_out = SFNC_OP_HALF_TO_F32;
    data_out = 32'h0000_0000;
    rtz_out = 1'b0;
  end
  // never present while reset is low; request holds until the next edge takes it
  task automatic present(input sfnc_op_t op, input logic [31:0] d, input logic rz, input logic en);
    @(posedge clk_in);
    while (reset_n_in !== 1'b1) @(posedge clk_in);
    valid_out <= 1'b1;
    op_out <= op;
    data_out <= d;
    rtz_out <= rz;
    enable_out <= en;
  endtask
  // released operand is inverted so a stale word is never mistaken for live data
  task automatic idle();
    @(posedge clk_in);
    valid_out <= 1'b0;
    enable_out <= 1'b1;
    data_out <= ~data_out;
  endtask
endmodule

// ---- sim/tb.sv ----
// self-checking testbench for the converter with one register stage
`timescale 1ns/1ps
module tb;
  import sfnc_pkg::*;
  localparam int NW = 8;
  logic clk_in, reset_n_in, enable_in, valid_in, round_to_zero_in, rz;
  logic valid_out, special_out;
  sfnc_op_t op_in;
  logic [31:0] data_in, result_out;
  int mismatches, cmp_count;

  always #10 clk_in = ~clk_in;

  sfnc_converter #(.NORM_W(NW)) sfnc_converter_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .enable_in(enable_in), .valid_in(valid_in), .op_in(op_in), .data_in(data_in),
    .round_to_zero_in(round_to_zero_in), .valid_out(valid_out), .result_out(result_out),
    .special_out(special_out));
  sfnc_feed_model sfnc_feed_model_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .enable_out(enable_in), .valid_out(valid_in), .op_out(op_in), .data_out(data_in),
    .rtz_out(round_to_zero_in));

  task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_bit(input string what, input logic e, input logic g);
    chk_word(what, {31'h0, e}, {31'h0, g});
  endtask
  // one request, taken one edge later, result looked at once it has settled
  task automatic xfer(input sfnc_op_t o, input logic [31:0] d, input logic [31:0] e, input logic sp);
    sfnc_feed_model_inst.present(o, d, rz, 1'b1);
    sfnc_feed_model_inst.idle();
    #1;
    chk_bit("valid_out", 1'b1, valid_out);
    chk_word($sformatf("result op %0d in %h", o, d), e, result_out);
    chk_bit($sformatf("special op %0d in %h", o, d), sp, special_out);
  endtask

  task automatic test_decode();
    xfer(SFNC_OP_HALF_TO_F32, 32'h0000_0000, 32'h0000_0000, 1'b0);
    xfer(SFNC_OP_HALF_TO_F32, 32'h0000_8000, 32'h8000_0000, 1'b0);
    xfer(SFNC_OP_HALF_TO_F32, 32'h0000_0001, 32'h3380_0000, 1'b0);
    xfer(SFNC_OP_HALF_TO_F32, 32'h0000_83ff, 32'hb87f_c000, 1'b0);
    xfer(SFNC_OP_HALF_TO_F32, 32'h0000_c000, 32'hc000_0000, 1'b0);
    xfer(SFNC_OP_HALF_TO_F32, 32'h0000_7bff, 32'h477f_e000, 1'b0);
    xfer(SFNC_OP_HALF_TO_F32, 32'h0000_fc00, 32'hff80_0000, 1'b1);
    xfer(SFNC_OP_HALF_TO_F32, 32'h0000_7e00, 32'h7fc0_0000, 1'b1);
    xfer(SFNC_OP_UF11_TO_F32, 32'h0000_03c0, 32'h3f80_0000, 1'b0);
    xfer(SFNC_OP_UF11_TO_F32, 32'h0000_0001, 32'h3580_0000, 1'b0);
    xfer(SFNC_OP_UF11_TO_F32, 32'h0000_07bf, 32'h477e_0000, 1'b0);
    xfer(SFNC_OP_UF11_TO_F32, 32'h0000_07c0, 32'h7f80_0000, 1'b1);
    xfer(SFNC_OP_UF11_TO_F32, 32'h0000_07e1, 32'h7fc2_0000, 1'b1);
    xfer(SFNC_OP_UF10_TO_F32, 32'h0000_01e0, 32'h3f80_0000, 1'b0);
    xfer(SFNC_OP_UF10_TO_F32, 32'h0000_0001, 32'h3600_0000, 1'b0);
    xfer(SFNC_OP_UF10_TO_F32, 32'h0000_03df, 32'h477c_0000, 1'b0);
    xfer(SFNC_OP_UF10_TO_F32, 32'h0000_03f0, 32'h7fc0_0000, 1'b1);
    $display("test decode done");
  endtask

  task automatic test_encode();
    xfer(SFNC_OP_F32_TO_UF11, 32'h3f80_0000, 32'h0000_03c0, 1'b0);
    xfer(SFNC_OP_F32_TO_UF11, 32'h3f81_0000, 32'h0000_03c0, 1'b0);
    xfer(SFNC_OP_F32_TO_UF11, 32'h3f83_0000, 32'h0000_03c2, 1'b0);
    xfer(SFNC_OP_F32_TO_UF11, 32'h3580_0000, 32'h0000_0001, 1'b0);
    xfer(SFNC_OP_F32_TO_UF11, 32'h477f_ff00, 32'h0000_07bf, 1'b0);
    xfer(SFNC_OP_F32_TO_UF11, 32'h4780_0000, 32'h0000_07bf, 1'b0);
    xfer(SFNC_OP_F32_TO_UF11, 32'hbf80_0000, 32'h0000_0000, 1'b0);
    xfer(SFNC_OP_F32_TO_UF11, 32'hff80_0000, 32'h0000_0000, 1'b1);
    xfer(SFNC_OP_F32_TO_UF11, 32'h7f80_0000, 32'h0000_07c0, 1'b1);
    xfer(SFNC_OP_F32_TO_UF11, 32'hffc0_0000, 32'h0000_07e0, 1'b1);
    xfer(SFNC_OP_F32_TO_UF10, 32'h3f80_0000, 32'h0000_01e0, 1'b0);
    xfer(SFNC_OP_F32_TO_UF10, 32'h3f86_0000, 32'h0000_01e2, 1'b0);
    xfer(SFNC_OP_F32_TO_UF10, 32'h477f_ff00, 32'h0000_03df, 1'b0);
    xfer(SFNC_OP_F32_TO_UF10, 32'h8000_0000, 32'h0000_0000, 1'b0);
    xfer(SFNC_OP_F32_TO_UF10, 32'h7f80_0000, 32'h0000_03e0, 1'b1);
    xfer(SFNC_OP_F32_TO_UF10, 32'h7fc0_0000, 32'h0000_03f0, 1'b1);
    rz = 1'b1;
    xfer(SFNC_OP_F32_TO_UF11, 32'h3f83_0000, 32'h0000_03c1, 1'b0);
    xfer(SFNC_OP_F32_TO_UF10, 32'h3f86_0000, 32'h0000_01e1, 1'b0);
    rz = 1'b0;
    $display("test encode done");
  endtask

  task automatic test_fixed_norm();
    xfer(SFNC_OP_FIX_TO_F32, 32'h0001_0000, 32'h3f80_0000, 1'b0);
    xfer(SFNC_OP_FIX_TO_F32, 32'hffff_0000, 32'hbf80_0000, 1'b0);
    xfer(SFNC_OP_FIX_TO_F32, 32'h8000_0000, 32'hc700_0000, 1'b0);
    xfer(SFNC_OP_FIX_TO_F32, 32'h0000_8000, 32'h3f00_0000, 1'b0);
    xfer(SFNC_OP_UNORM_TO_F32, 32'h0000_00ff, 32'h3f80_0000, 1'b0);
    xfer(SFNC_OP_UNORM_TO_F32, 32'h0000_0001, 32'h3b80_8080, 1'b0);
    xfer(SFNC_OP_UNORM_TO_F32, 32'h0000_0000, 32'h0000_0000, 1'b0);
    xfer(SFNC_OP_SNORM_TO_F32, 32'h0000_0081, 32'hbf80_0000, 1'b0);
    xfer(SFNC_OP_SNORM_TO_F32, 32'h0000_0080, 32'hbf80_0000, 1'b0);
    xfer(SFNC_OP_SNORM_TO_F32, 32'h0000_007f, 32'h3f80_0000, 1'b0);
    xfer(SFNC_OP_SNORM_TO_F32, 32'h0000_0001, 32'h3c01_0204, 1'b0);
    xfer(SFNC_OP_F32_TO_UNORM, 32'h4000_0000, 32'h0000_00ff, 1'b0);
    xfer(SFNC_OP_F32_TO_UNORM, 32'h3f80_0000, 32'h0000_00ff, 1'b0);
    xfer(SFNC_OP_F32_TO_UNORM, 32'hbf80_0000, 32'h0000_0000, 1'b0);
    xfer(SFNC_OP_F32_TO_UNORM, 32'h3f00_0000, 32'h0000_0080, 1'b0);
    xfer(SFNC_OP_F32_TO_SNORM, 32'hc000_0000, 32'hffff_ff81, 1'b0);
    xfer(SFNC_OP_F32_TO_SNORM, 32'hbf80_0000, 32'hffff_ff81, 1'b0);
    xfer(SFNC_OP_F32_TO_SNORM, 32'h3f80_0000, 32'h0000_007f, 1'b0);
    xfer(SFNC_OP_F32_TO_SNORM, 32'hbf00_0000, 32'hffff_ffc0, 1'b0);
    xfer(SFNC_OP_F32_TO_SNORM, 32'h0000_0000, 32'h0000_0000, 1'b0);
    $display("test fixed and normalized done");
  endtask

  // back to back requests, a frozen stretch, then a reset while frozen
  task automatic test_flow();
    sfnc_feed_model_inst.present(SFNC_OP_HALF_TO_F32, 32'h0000_3c00, 1'b0, 1'b1);
    sfnc_feed_model_inst.present(SFNC_OP_UF11_TO_F32, 32'h0000_07c0, 1'b0, 1'b1);
    #1;
    chk_word("first of pair", 32'h3f80_0000, result_out);
    sfnc_feed_model_inst.present(SFNC_OP_HALF_TO_F32, 32'h0000_c000, 1'b0, 1'b0);
    #1;
    chk_bit("second of pair special", 1'b1, special_out);
    repeat (3) begin
      @(posedge clk_in);
      #1;
      chk_word("frozen result", 32'h7f80_0000, result_out);
    end
    sfnc_feed_model_inst.present(SFNC_OP_HALF_TO_F32, 32'h0000_c000, 1'b0, 1'b1);
    sfnc_feed_model_inst.idle();
    #1;
    chk_word("after thaw", 32'hc000_0000, result_out);
    sfnc_feed_model_inst.idle();
    #1;
    chk_bit("idle valid", 1'b0, valid_out);
    chk_word("idle result held", 32'hc000_0000, result_out);
    sfnc_feed_model_inst.present(SFNC_OP_HALF_TO_F32, 32'h0000_3c00, 1'b0, 1'b0);
    reset_n_in <= 1'b0;
    @(posedge clk_in);
    #1;
    chk_word("reset while frozen", 32'h0000_0000, result_out);
    sfnc_feed_model_inst.idle();
    reset_n_in <= 1'b1;
    for (int k = 10; k < 16; k++) begin
      xfer(SFNC_OP_FIX_TO_F32, 32'h0001_0000, 32'h3f80_0000, 1'b0);
      sfnc_feed_model_inst.present(sfnc_op_t'(k), 32'h3f80_0000, 1'b0, 1'b1);
      sfnc_feed_model_inst.idle();
      #1;
      chk_word($sformatf("unused op %0d", k), 32'h0000_0000, result_out);
    end
    $display("test flow done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    reset_n_in = 1'b0;
    rz = 1'b0;
    repeat (7) @(posedge clk_in);
    #1;
    chk_word("reset result", 32'h0000_0000, result_out);
    chk_bit("reset valid", 1'b0, valid_out);
    @(posedge clk_in);
    reset_n_in <= 1'b1;
    test_decode();
    test_encode();
    test_fixed_norm();
    test_flow();
    tally_and_finish();
  end

  // the run needs about 154 cycles (some 3 us); this bound cuts a hang short
  initial begin
    #50us;
    mismatches++;
    $display("[ERR] watchdog expired");
    tally_and_finish();
  end
endmodule
